// ===== rtl/aesr_top.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R1] The action byte holds a remark enable at bit 2, a priority mode at 7:6 and a priority at 5:3.
// [R2] The 3-bit remark priority keeps its upper two bits at 1:0 of the action byte, its LSB at bit 7 of the next.
// [R3] A 7-bit forward map at bits 6:0 holds one bit per port, set to forward, clear to forbid.
// [R4] Forward map bit k stands for switch port k+1.
// [R5] High byte-select bit 0 selects staging byte 7, rising bits fall to byte 0 at bit 7.
// [R6] Low byte-select bit 0 selects staging byte F, rising bits fall to byte 8 at bit 7.
// [R7] A write of the low byte-select register starts a table transfer, so it is written last.
// [R8] Only staging bytes whose select bit is 1 move; the rest stay untouched.
// [R9] The read-complete flag drops while a table read runs and rises when it ends; software polls it.
// [R10] The write-complete flag is 0 while a table write is pending, 1 after, and resets to 1.
// [R11] Software sets direction and entry index before writing the low byte-select register.
module aesr_top
  import aesr_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  output logic             TBL_REQ,
  output logic             TBL_WR,
  output logic      [3:0]  TBL_IDX,
  output logic      [15:0] TBL_BYTE_EN,
  output logic      [55:0] TBL_WDATA,
  input  wire logic        TBL_DONE,
  input  wire logic [55:0] TBL_RDATA,
  output logic      [7:1]  FWD_PORT_MAP
);
  import aesr_pkg::*;

  // ==========================================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  // Release is synchronised so that no flop leaves reset on a split edge
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Decoding helpers

  // Byte-select registers are listed highest byte first; turn them into byte order
  function automatic logic [15:0] sel_to_bytes(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] cat;
    logic [15:0] res;
    cat = {hi, lo};
    res = 16'h0000;
    for (int b = 0; b < 16; b++) begin
      res[b] = cat[15-b];  // [R5] [R6]
    end
    return res;
  endfunction

  // True when the offset falls on a staging byte of this block
  function automatic logic is_stage(input logic [7:0] addr);
    return (addr >= AESR_OFF_ETYPE_LO) && (addr <= AESR_OFF_RULE_LO);
  endfunction

  // Control byte as software sees it; shared by the read path and its check
  function automatic logic [7:0] ctrl_byte(input aesr_state_s s);
    return {1'b0, s.wr_done, s.rd_done, s.dir, s.idx};
  endfunction

  // ==========================================================================
  // State
  aesr_state_s r_reg;
  aesr_state_s r_next;
  logic [2:0]  slot;
  logic        trig;
  logic        tbl_end;

  assign slot = 3'(REG_ADDR - AESR_OFF_ETYPE_LO);
  // Completion only counts while a request is out; stray pulses are ignored
  assign tbl_end = r_reg.busy && TBL_DONE;
  // A trigger while a transfer is pending is dropped; the table has one port
  assign trig = REG_WR && (REG_ADDR == AESR_OFF_BSEL_LO) && !r_reg.busy;

  // Next state: bus reads and writes, then table completion
  always_comb begin
    r_next       = r_reg;
    r_next.rdata = AESR_BYTE_RST;
    if (REG_RD) begin
      if (is_stage(REG_ADDR)) begin
        r_next.rdata = r_reg.stage[slot];  // [R1] [R2] [R3]
      end else if (REG_ADDR == AESR_OFF_BSEL_HI) begin
        r_next.rdata = r_reg.bsel_hi;
      end else if (REG_ADDR == AESR_OFF_BSEL_LO) begin
        r_next.rdata = r_reg.bsel_lo;
      end else if (REG_ADDR == AESR_OFF_ACC_CTRL) begin
        r_next.rdata = ctrl_byte(r_reg);  // [R9] [R10]
      end
    end
    if (REG_WR) begin
      if (is_stage(REG_ADDR)) begin
        r_next.stage[slot] = REG_WDATA;
      end else if (REG_ADDR == AESR_OFF_BSEL_HI) begin
        r_next.bsel_hi = REG_WDATA;
      end else if (REG_ADDR == AESR_OFF_BSEL_LO) begin
        r_next.bsel_lo = REG_WDATA;
      end else if (REG_ADDR == AESR_OFF_ACC_CTRL && !r_reg.busy) begin
        // Direction and index are frozen while a transfer runs
        r_next.dir = REG_WDATA[AESR_CTL_DIR];
        r_next.idx = REG_WDATA[AESR_CTL_IDX_HI:0];
      end
    end
    if (trig) begin
      r_next.busy   = 1'b1;  // [R7]
      r_next.req_en = sel_to_bytes(r_reg.bsel_hi, REG_WDATA);
      if (r_reg.dir) begin
        r_next.wr_done = 1'b0;  // [R10]
      end else begin
        r_next.rd_done = 1'b0;  // [R9]
      end
    end
    if (tbl_end) begin
      r_next.busy = 1'b0;
      if (r_reg.dir) begin
        r_next.wr_done = 1'b1;  // [R10]
      end else begin
        r_next.rd_done = 1'b1;  // [R9]
        // Table data wins over a bus write landing in the same cycle
        for (int k = 0; k < AESR_NSTAGE; k++) begin
          if (r_reg.req_en[k + AESR_FIRST_BYTE]) begin
            r_next.stage[k] = TBL_RDATA[k*8 +: 8];  // [R8]
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      r_reg.stage   <= {AESR_NSTAGE{AESR_BYTE_RST}};
      r_reg.bsel_hi <= AESR_BSEL_RST;
      r_reg.bsel_lo <= AESR_BSEL_RST;
      r_reg.req_en  <= {AESR_BSEL_RST, AESR_BSEL_RST};
      r_reg.dir     <= 1'b0;
      r_reg.idx     <= AESR_IDX_RST;
      r_reg.wr_done <= 1'b1;  // [R10]
      r_reg.rd_done <= 1'b1;
      r_reg.busy    <= 1'b0;
      r_reg.rdata   <= AESR_BYTE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs, all taken from state flops
  assign REG_RDATA    = r_reg.rdata;
  assign TBL_REQ      = r_reg.busy;
  assign TBL_WR       = r_reg.dir;
  assign TBL_IDX      = r_reg.idx;
  assign TBL_BYTE_EN  = r_reg.req_en;  // [R5] [R6]
  assign TBL_WDATA    = r_reg.stage;   // Table writes only the enabled bytes [R8]
  assign FWD_PORT_MAP = r_reg.stage[AESR_OFF_FWD_MAP - AESR_OFF_ETYPE_LO][AESR_FWD_MSB:0];  // [R3] [R4]

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n_reg);

  trig_start_a: assert property (trig |=> TBL_REQ && r_reg.busy)  // [R7]
    else $error("Low select write did not start a transfer");
  rd_flag_clr_a: assert property (trig && !r_reg.dir |=> !r_reg.rd_done [*1] ##0 TBL_REQ)  // [R9]
    else $error("Read flag not cleared at read start");
  rd_flag_set_a: assert property (r_reg.busy && TBL_DONE && !r_reg.dir |=> r_reg.rd_done && !TBL_REQ)  // [R9]
    else $error("Read flag not set at read end");
  wr_flag_a: assert property (trig && r_reg.dir |=> !r_reg.wr_done && TBL_REQ) // [R10]
    else $error("Write flag not cleared at write start");
  wr_done_a: assert property (r_reg.busy && TBL_DONE && r_reg.dir |=> r_reg.wr_done && r_reg.rd_done) // [R10]
    else $error("Write flag not set at write end");
  byte_load_a: assert property (r_reg.busy && TBL_DONE && !r_reg.dir && r_reg.req_en[9]
    |=> r_reg.stage[0] == $past(TBL_RDATA[7:0]))  // [R8]
    else $error("Enabled byte not loaded from table");
  byte_keep_a: assert property (r_reg.busy && TBL_DONE && !r_reg.dir && !r_reg.req_en[15]
    && !(REG_WR && REG_ADDR == AESR_OFF_RULE_LO) |=> $stable(r_reg.stage[6]))  // [R8]
    else $error("Disabled byte was changed");
  sel_order_a: assert property (trig |=> TBL_BYTE_EN[15] == $past(REG_WDATA[0])
    && TBL_BYTE_EN[8] == $past(REG_WDATA[7]) && TBL_BYTE_EN[7] == r_reg.bsel_hi[0]
    && TBL_BYTE_EN[0] == r_reg.bsel_hi[7])  // [R5] [R6]
    else $error("Byte select order wrong");
  act_read_a: assert property (REG_RD && REG_ADDR == AESR_OFF_PRIO_ACT && !REG_WR
    |=> REG_RDATA[AESR_REMARK_EN_BIT] == $past(r_reg.stage[1][AESR_REMARK_EN_BIT])
    && REG_RDATA[AESR_REMARK_MSB_HI:0] == $past(r_reg.stage[1][AESR_REMARK_MSB_HI:0]))  // [R1] [R2]
    else $error("Action byte read back wrong");
  fwd_port_a: assert property (REG_WR && REG_ADDR == AESR_OFF_FWD_MAP && !r_reg.busy
    |=> FWD_PORT_MAP[1] == $past(REG_WDATA[0]) && FWD_PORT_MAP[7] == $past(REG_WDATA[6]))  // [R3] [R4]
    else $error("Forward map port order wrong");

  // ==========================================================================
  // Bus read path, status flags, request handshake, byte enables, staging and forward map

  // Read data is zero outside the answer cycle
  rdata_idle_a: assert property (!REG_RD  // [R9]
    |=> REG_RDATA == AESR_BYTE_RST)
    else $error("Read data not idle");

  // Control byte reads back the live flags, direction and index
  ctrl_read_a: assert property (REG_RD && REG_ADDR == AESR_OFF_ACC_CTRL  // [R9] [R10]
    |=> REG_RDATA == $past(ctrl_byte(r_reg)))
    else $error("Control byte read back wrong");

  // With no transfer out both completion flags must stand high
  flags_idle_a: assert property (!r_reg.busy  // [R9] [R10]
    |-> r_reg.rd_done && r_reg.wr_done)
    else $error("Done flag low while idle");

  // While busy the flag of the running direction stays low
  flag_busy_a: assert property (r_reg.busy  // [R9] [R10]
    |-> (r_reg.dir ? !r_reg.wr_done : !r_reg.rd_done))
    else $error("Done flag high while busy");

  // Request and its qualifiers hold until completion is seen
  req_hold_a: assert property (TBL_REQ && !TBL_DONE  // [R7]
    |=> TBL_REQ && $stable(TBL_WR) && $stable(TBL_IDX) && $stable(TBL_BYTE_EN))
    else $error("Request dropped or changed early");

  // Request falls one edge after completion
  req_end_a: assert property (tbl_end  // [R7]
    |=> !TBL_REQ)
    else $error("Request did not end");

  // Byte enables move only on a trigger
  sel_keep_a: assert property (!trig  // [R5] [R6]
    |=> $stable(TBL_BYTE_EN))
    else $error("Byte enables changed without trigger");

  // A trigger while busy is dropped and leaves the request alone
  trig_drop_a: assert property (REG_WR && REG_ADDR == AESR_OFF_BSEL_LO && r_reg.busy  // [R7]
    && !TBL_DONE |=> TBL_REQ && $stable(TBL_BYTE_EN))
    else $error("Trigger accepted while busy");

  // Direction and index cannot be changed under a running transfer
  ctrl_frozen_a: assert property (REG_WR && REG_ADDR == AESR_OFF_ACC_CTRL && r_reg.busy  // [R7]
    |=> $stable(TBL_IDX) && $stable(TBL_WR))
    else $error("Control changed while busy");

  // Direction and index load when idle
  ctrl_load_a: assert property (REG_WR && REG_ADDR == AESR_OFF_ACC_CTRL && !r_reg.busy  // [R7]
    |=> TBL_IDX == $past(REG_WDATA[AESR_CTL_IDX_HI:0]) && TBL_WR == $past(REG_WDATA[AESR_CTL_DIR]))
    else $error("Control not loaded");

  // High select bits map downwards onto staging bytes 7 to 0
  sel_hi_mid_a: assert property (trig  // [R5]
    |=> TBL_BYTE_EN[4] == r_reg.bsel_hi[3] && TBL_BYTE_EN[3] == r_reg.bsel_hi[4])
    else $error("High select middle bits wrong");

  // A write transfer leaves staging untouched
  wr_keep_a: assert property (tbl_end && r_reg.dir && !REG_WR  // [R8]
    |=> $stable(r_reg.stage))
    else $error("Write transfer altered staging");

  // Top staging byte loads from the top table lane
  byte_load_hi_a: assert property (tbl_end && !r_reg.dir && r_reg.req_en[15]  // [R8]
    |=> r_reg.stage[6] == $past(TBL_RDATA[55:48]))
    else $error("Top byte not loaded from table");

  // A bus write to the action byte lands when no table load competes
  act_write_a: assert property (REG_WR && REG_ADDR == AESR_OFF_PRIO_ACT && !tbl_end  // [R1] [R2]
    |=> r_reg.stage[1] == $past(REG_WDATA))
    else $error("Action byte write lost");

  // Priority mode and priority read back in place
  prio_read_a: assert property (REG_RD && REG_ADDR == AESR_OFF_PRIO_ACT  // [R1]
    |=> REG_RDATA[AESR_PRIO_SEL_HI:AESR_PRIO_LO] == $past(r_reg.stage[1][AESR_PRIO_SEL_HI:AESR_PRIO_LO]))
    else $error("Priority fields read back wrong");

  // Remark LSB sits at the top of the following byte
  remark_lsb_a: assert property (REG_RD && REG_ADDR == AESR_OFF_REMARK_MM  // [R2]
    |=> REG_RDATA[AESR_REMARK_LSB] == $past(r_reg.stage[2][AESR_REMARK_LSB]))
    else $error("Remark LSB read back wrong");

  // The port pins mirror the forward map byte as read by software
  fwd_read_a: assert property (REG_RD && REG_ADDR == AESR_OFF_FWD_MAP  // [R3] [R4]
    |=> REG_RDATA[AESR_FWD_MSB:0] == $past(FWD_PORT_MAP))
    else $error("Forward map pins differ from register");

  // Forward map only moves on a bus write or a table load
  fwd_hold_a: assert property (!REG_WR && !tbl_end  // [R3]
    |=> $stable(FWD_PORT_MAP))
    else $error("Forward map changed on its own");

endmodule // aesr_top
`default_nettype wire

// ===== rtl/aesr_pkg.sv
package aesr_pkg;

  // ==========================================================================
  // Register offsets (low byte of the per-port table page)
  localparam logic [7:0] AESR_OFF_ETYPE_LO  = 8'h09;
  localparam logic [7:0] AESR_OFF_PRIO_ACT  = 8'h0A;
  localparam logic [7:0] AESR_OFF_REMARK_MM = 8'h0B;
  localparam logic [7:0] AESR_OFF_SPARE     = 8'h0C;
  localparam logic [7:0] AESR_OFF_FWD_MAP   = 8'h0D;
  localparam logic [7:0] AESR_OFF_RULE_HI   = 8'h0E;
  localparam logic [7:0] AESR_OFF_RULE_LO   = 8'h0F;
  localparam logic [7:0] AESR_OFF_BSEL_HI   = 8'h10;
  localparam logic [7:0] AESR_OFF_BSEL_LO   = 8'h11;
  localparam logic [7:0] AESR_OFF_ACC_CTRL  = 8'h12;

  // ==========================================================================
  // Staging layout: this block holds staging bytes 9 to F
  localparam int         AESR_NSTAGE     = 7;
  localparam logic [3:0] AESR_FIRST_BYTE = 4'h9;
  localparam logic [7:0] AESR_BYTE_RST   = 8'h00;
  localparam logic [7:0] AESR_BSEL_RST   = 8'h00;
  localparam logic [3:0] AESR_IDX_RST    = 4'h0;

  // ==========================================================================
  // Field positions
  localparam int AESR_PRIO_SEL_HI   = 7;  // priority_action_select 7:6
  localparam int AESR_PRIO_SEL_LO   = 6;
  localparam int AESR_PRIO_HI       = 5;  // priority 5:3
  localparam int AESR_PRIO_LO       = 3;
  localparam int AESR_REMARK_EN_BIT = 2;  // remark_enable_bit
  localparam int AESR_REMARK_MSB_HI = 1;  // remark priority [2:1]
  localparam int AESR_REMARK_LSB    = 7;  // remark priority [0] in next byte
  localparam int AESR_MAP_SEL_HI    = 6;  // forward_map_select 6:5
  localparam int AESR_MAP_SEL_LO    = 5;
  localparam int AESR_FWD_MSB       = 6;  // forward map 6:0
  localparam int AESR_CTL_WR_DONE   = 6;
  localparam int AESR_CTL_RD_DONE   = 5;
  localparam int AESR_CTL_DIR       = 4;
  localparam int AESR_CTL_IDX_HI    = 3;

  // ==========================================================================
  // Block state
  typedef struct packed {
    logic [AESR_NSTAGE-1:0][7:0] stage;   // index 0 is staging byte 9
    logic [7:0]                  bsel_hi;
    logic [7:0]                  bsel_lo;
    logic [15:0]                 req_en;  // bit b enables staging byte b
    logic                        dir;     // 1 write, 0 read
    logic [3:0]                  idx;
    logic                        wr_done;
    logic                        rd_done;
    logic                        busy;
    logic [7:0]                  rdata;
  } aesr_state_s;

endpackage

// ===== tb/aesr_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import aesr_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  logic        CLK_SYS     = 1'b0;
  logic        ARST_N      = 1'b0;
  logic [7:0]  REG_ADDR    = 8'h00;
  logic [7:0]  REG_WDATA   = 8'h00;
  logic        REG_WR      = 1'b0;
  logic        REG_RD      = 1'b0;
  logic        TBL_DONE    = 1'b0;
  logic [55:0] TBL_RDATA   = 56'h0;
  logic [7:0]  REG_RDATA;
  logic        TBL_REQ, TBL_WR;
  logic [3:0]  TBL_IDX;
  logic [15:0] TBL_BYTE_EN;
  logic [55:0] TBL_WDATA, stg;
  logic [7:1]  FWD_PORT_MAP;
  logic [7:0]  d, hi, lo;
  int          errors = 0, n_tests = 0, cyc = 0;
  integer      seed = 32'h95da;

  aesr_top dut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .TBL_REQ(TBL_REQ), .TBL_WR(TBL_WR), .TBL_IDX(TBL_IDX), .TBL_BYTE_EN(TBL_BYTE_EN),
    .TBL_WDATA(TBL_WDATA), .TBL_DONE(TBL_DONE), .TBL_RDATA(TBL_RDATA),
    .FWD_PORT_MAP(FWD_PORT_MAP));

  // ==========================================================================
  // Clock, verdict and hang guard
  always #2 CLK_SYS = ~CLK_SYS;
  task automatic complete_run;
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A stuck handshake would otherwise spin forever
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      complete_run;
    end
  end

  // ==========================================================================
  // Bus cycles: one-cycle strobes, read data sampled in the following cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK_SYS) begin REG_ADDR <= a; REG_WDATA <= v; REG_WR <= 1'b1; end
    @(posedge CLK_SYS) REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLK_SYS) begin REG_ADDR <= a; REG_RD <= 1'b1; end
    @(posedge CLK_SYS) REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask
  // Low select counts down from byte F, high select down from byte 7
  function automatic logic [15:0] ben(input logic [7:0] h, input logic [7:0] l);
    for (int i = 0; i < 8; i++) begin
      ben[15-i] = l[i];
      ben[7-i]  = h[i];
    end
  endfunction

  // One table transfer with a stalled completion from the table side
  task automatic xfer(input logic dir, input logic [3:0] idx);
    logic [63:0] r;
    logic [15:0] en;
    en = ben(hi, lo);
    r  = {$random(seed), $random(seed)};
    wr(AESR_OFF_ACC_CTRL, {3'b000, dir, idx});
    wr(AESR_OFF_BSEL_HI, hi);
    wr(AESR_OFF_BSEL_LO, lo);
    #1 `CHK(TBL_REQ, 1'b1)
    `CHK({TBL_WR, TBL_IDX, TBL_BYTE_EN}, {dir, idx, en})
    if (dir) `CHK(TBL_WDATA, stg)
    rd(AESR_OFF_ACC_CTRL, d);
    `CHK(d, {1'b0, ~dir, dir, dir, idx})
    // Control and trigger writes under a running transfer must be refused
    wr(AESR_OFF_ACC_CTRL, {3'b000, ~dir, ~idx});
    wr(AESR_OFF_BSEL_LO, lo);
    #1 `CHK({TBL_REQ, TBL_WR, TBL_IDX, TBL_BYTE_EN}, {1'b1, dir, idx, en})
    repeat (2'($random(seed))) @(posedge CLK_SYS);
    @(posedge CLK_SYS) begin TBL_DONE <= 1'b1; TBL_RDATA <= r[55:0]; end
    @(posedge CLK_SYS) begin TBL_DONE <= 1'b0; TBL_RDATA <= ~r[55:0]; end
    #1 `CHK(TBL_REQ, 1'b0)
    if (!dir) for (int b = 9; b < 16; b++) if (en[b]) stg[(b-9)*8 +: 8] = r[(b-9)*8 +: 8];
    rd(AESR_OFF_ACC_CTRL, d);
    `CHK(d, {3'b011, dir, idx})
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    stg = 56'h0;
    repeat (10) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    // Reset values, unmapped place ignored and reading zero
    for (int a = 9; a < 18; a++) begin
      rd(8'(a), d);
      `CHK(d, 8'h00)
    end
    rd(AESR_OFF_ACC_CTRL, d);
    `CHK(d, 8'h60)
    wr(8'h20, 8'hA5);
    rd(8'h20, d);
    `CHK(d, 8'h00)
    for (int it = 0; it < 10; it++) begin
      for (int a = 0; a < 7; a++) begin
        d = 8'($random(seed));
        stg[a*8 +: 8] = d;
        wr(AESR_FIRST_BYTE + 8'(a), d);
      end
      #1 `CHK(FWD_PORT_MAP, stg[38:32])
      for (int a = 0; a < 7; a++) begin
        rd(AESR_FIRST_BYTE + 8'(a), d);
        `CHK(d, stg[a*8 +: 8])
      end
      hi = (it < 2) ? {8{it[0]}} : 8'($random(seed));
      lo = (it < 2) ? {8{it[0]}} : 8'($random(seed));
      xfer(it[1] ^ it[0], 4'($random(seed)));
      for (int a = 0; a < 7; a++) begin
        rd(AESR_FIRST_BYTE + 8'(a), d);
        `CHK(d, stg[a*8 +: 8])
      end
      rd(AESR_OFF_BSEL_LO, d);
      `CHK(d, lo)
    end
    complete_run;
  end
endmodule // testbench
`default_nettype wire
